//--- core/qbp_host.sv
// Memory controller end: clock generation, command issue, write beats, read capture
`timescale 1ns/1ps
module qbp_host (
   // System
   input wire logic clk,
   input wire logic reset_n,
   // Link
   qbp_link_if.host link,
   // Mode
   input wire logic dbg_no_pll,
   input wire logic use_k_out,
   input wire logic clk_stop,
   // Request
   input wire logic req_valid,
   input wire logic req_write,
   input wire qbp_pkg::qbp_addr_t req_addr,
   input wire logic [qbp_pkg::BEATS*qbp_pkg::DATA_W-1:0] req_wdata,
   input wire logic [qbp_pkg::BEATS*qbp_pkg::LANES-1:0] req_mask_n,
   output logic rd_ready,
   output logic wr_ready,
   // Answer
   output logic rd_valid,
   output qbp_pkg::qbp_word_t rd_data,
   output logic link_up
);
   import qbp_pkg::*;

   qbp_hstate_e st_ff, nxt_st;
   logic [LOCK_W-1:0] cnt_ff, nxt_cnt;
   logic phase_ff, k_ff, kn_ff, held_ff, byp_n_ff, rd_n_ff, wr_n_ff;
   logic rd_last_ff, wr_act_ff, nxt_wr_act, edge_d_ff, rd_ready_ff, wr_ready_ff, rd_valid_ff;
   logic [2:0] idx_ff, nxt_idx;
   qbp_addr_t addr_ff;
   qbp_word_t d_ff, rd_data_ff;
   qbp_mask_t mask_ff;
   logic [BEATS*DATA_W-1:0] wbuf_ff;
   logic [BEATS*LANES-1:0] mbuf_ff;

   // A taken request always gets its K edge, even if a stop arrives with it
   wire take_rd = req_valid && !req_write && rd_ready_ff;
   wire take_wr = req_valid && req_write && wr_ready_ff;
   wire take = take_rd || take_wr;
   wire run = !clk_stop || take;
   // Fixed divide by two keeps the K rate steady; the frequency floor is notional at this scale
   wire k_gen = run && phase_ff;
   wire kn_gen = run && !phase_ff;
   wire nxt_phase = run ? !phase_ff : phase_ff;

   // Lock wait counts K edges past the lock time; bypass skips it
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      case (st_ff)
         HS_WAIT: begin
            if (dbg_no_pll) begin
               nxt_st = HS_RUN;
            end else if (k_gen) begin
               nxt_cnt = cnt_ff + 1'b1;
               if (cnt_ff == LOCK_HOST) begin
                  nxt_st = HS_RUN;
               end
            end
         end
         HS_RUN: begin
            if (!dbg_no_pll && !byp_n_ff) begin
               nxt_st = HS_WAIT;
               nxt_cnt = '0;
            end
         end
         default: begin
            nxt_st = HS_WAIT;
         end
      endcase
   end

   // Slot readiness; same type never on consecutive K edges
   wire nxt_slot = (nxt_st == HS_RUN) && nxt_phase;
   wire rd_last_now = k_gen ? take_rd : rd_last_ff;
   wire beat_edge = (k_gen || kn_gen) && wr_act_ff;
   assign nxt_idx = take_wr ? HIDX_SKIP : (beat_edge ? idx_ff + 1'b1 : idx_ff);
   assign nxt_wr_act = take_wr || (wr_act_ff && !(beat_edge && idx_ff == HIDX_LAST));
   wire [1:0] sel = 2'(idx_ff - 1'b1);
   wire beat_now = beat_edge && idx_ff != HIDX_SKIP;

   // Clock pair, output clocks and mode pins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_ff <= 1'b0;
         k_ff <= 1'b0;
         kn_ff <= 1'b0;
         held_ff <= 1'b0;
         byp_n_ff <= 1'b1;
      end else begin
         phase_ff <= nxt_phase;
         k_ff <= k_gen;
         kn_ff <= kn_gen;
         held_ff <= use_k_out;
         byp_n_ff <= !dbg_no_pll;
      end
   end

   // Lock state and readiness
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= HS_WAIT;
         cnt_ff <= '0;
         rd_last_ff <= 1'b0;
         rd_ready_ff <= 1'b0;
         wr_ready_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         rd_last_ff <= rd_last_now;
         rd_ready_ff <= nxt_slot && !rd_last_now;
         wr_ready_ff <= nxt_slot && !nxt_wr_act;
      end
   end

   // Command pins; selects high outside the issuing K, so writes after reads keep read select high
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         addr_ff <= '0;
      end else begin
         rd_n_ff <= !take_rd;
         wr_n_ff <= !take_wr;
         if (take) begin
            addr_ff <= req_addr;
         end
      end
   end

   // Write beats: skip K# of the command, then four words on K, K#, K, K#
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_act_ff <= 1'b0;
         idx_ff <= HIDX_SKIP;
         wbuf_ff <= '0;
         mbuf_ff <= '1;
         d_ff <= '0;
         mask_ff <= MASK_NONE;
      end else begin
         wr_act_ff <= nxt_wr_act;
         idx_ff <= nxt_idx;
         if (take_wr) begin
            wbuf_ff <= req_wdata;
            mbuf_ff <= req_mask_n;
         end
         d_ff <= beat_now ? wbuf_ff[sel*DATA_W +: DATA_W] : '0;
         mask_ff <= beat_now ? mbuf_ff[sel*LANES +: LANES] : MASK_NONE;
      end
   end

   // Read capture one cycle after each output edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         edge_d_ff <= 1'b0;
         rd_valid_ff <= 1'b0;
         rd_data_ff <= '0;
      end else begin
         edge_d_ff <= k_ff || kn_ff;
         rd_valid_ff <= edge_d_ff && !link.q_oe_n;
         rd_data_ff <= link.q;
      end
   end

   assign link.k_en = k_ff;
   assign link.kn_en = kn_ff;
   assign link.c_en = k_ff && !held_ff;
   assign link.cn_en = kn_ff && !held_ff;
   assign link.c_held = held_ff;
   assign link.pll_bypass_n = byp_n_ff;
   assign link.rd_sel_n = rd_n_ff;
   assign link.wr_sel_n = wr_n_ff;
   assign link.addr = addr_ff;
   assign link.d = d_ff;
   assign link.byte_write_mask_n = mask_ff;
   assign rd_ready = rd_ready_ff;
   assign wr_ready = wr_ready_ff;
   assign rd_valid = rd_valid_ff;
   assign rd_data = rd_data_ff;
   assign link_up = st_ff;
endmodule

//--- include/qbp_pkg.sv
// Shared constants and types for the burst-of-four SRAM port and its controller
// Notes on behaviour
// - PLL bypass low runs without PLL
// - Controller holds PLL bypass high normally
// - Stable clock over 20 us before commands
// - Input clock at least 120 MHz with PLL; K here runs at 12.5 MHz
// - No unstable clock while PLL enabled
// - Write words taken K t+1 to K# t+2
// - Read words out C# t+1 to C t+3
// - Output clocks held high: use input clocks
// - Selects sampled on true input clock only
// - Read outputs high impedance through power-up
// - Stopped clocks hold state; park clocks together
// - Read select ignored for write after read
// - No same-type commands on consecutive edges
// - Device ignores back-to-back same-type request
// - Idle cycle ignores address, outputs released
// - Burst words +0..+3 fixed, count four
// - Read wins when both selects low
// - Active-low byte masks gate each beat
package qbp_pkg;
   localparam int ADDR_W = 18;
   localparam int BEAT_W = 2;
   localparam int DATA_W = 18;
   localparam int LANE_W = 9;
   localparam int LANES = 2;
   localparam int BEATS = 4;
   localparam int DEPTH = 2 ** (ADDR_W + BEAT_W);
   // Link clock is clk divided by two: one K period is two clk cycles
   localparam int CLK_NS = 40;
   localparam int K_DIV = 2;
   localparam int PLL_LOCK_NS = 20000;
   localparam int LOCK_K = (PLL_LOCK_NS + CLK_NS * K_DIV - 1) / (CLK_NS * K_DIV);
   localparam int LOCK_W = 9;
   localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_K - 1);
   localparam logic [LOCK_W-1:0] LOCK_HOST = LOCK_W'(LOCK_K);
   localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
   localparam logic [BEAT_W-1:0] BEAT_SECOND = 2'h1;
   localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;
   localparam logic [2:0] HIDX_SKIP = 3'h0;
   localparam logic [2:0] HIDX_LAST = 3'h4;
   localparam logic [LANES-1:0] MASK_NONE = 2'h3;
   typedef logic [ADDR_W-1:0] qbp_addr_t;
   typedef logic [DATA_W-1:0] qbp_word_t;
   typedef logic [LANES-1:0] qbp_mask_t;
   typedef enum logic {DS_LOCK = 1'b0, DS_READY = 1'b1} qbp_dstate_e;
   typedef enum logic {HS_WAIT = 1'b0, HS_RUN = 1'b1} qbp_hstate_e;
endpackage

//--- include/qbp_link_if.sv
// Link between the SRAM port and its controller; clocks are enable pulses
`timescale 1ns/1ps
interface qbp_link_if;
   import qbp_pkg::*;
   logic k_en;
   logic kn_en;
   logic c_en;
   logic cn_en;
   logic c_held;
   logic pll_bypass_n;
   logic rd_sel_n;
   logic wr_sel_n;
   qbp_addr_t addr;
   qbp_word_t d;
   qbp_mask_t byte_write_mask_n;
   qbp_word_t q;
   logic q_oe_n;
   modport dev (input k_en, kn_en, c_en, cn_en, c_held, pll_bypass_n, rd_sel_n, wr_sel_n,
      addr, d, byte_write_mask_n, output q, q_oe_n);
   modport host (output k_en, kn_en, c_en, cn_en, c_held, pll_bypass_n, rd_sel_n, wr_sel_n,
      addr, d, byte_write_mask_n, input q, q_oe_n);
endinterface

//--- core/qbp_device.sv
// SRAM port: command decode, write and read burst engines, storage array
`timescale 1ns/1ps
module qbp_device (
   // System
   input wire logic clk,
   input wire logic reset_n,
   // Link
   qbp_link_if.dev link,
   // Status
   output logic pll_ready
);
   import qbp_pkg::*;

   qbp_dstate_e st_ff, nxt_st;
   logic [LOCK_W-1:0] lock_cnt_ff, nxt_lock_cnt;
   logic bypass_q_ff, ready_ff;
   logic rd_prev_ff, wr_prev_ff;
   logic wr_pend_ff, nxt_wr_pend, wr_act_ff, nxt_wr_act;
   qbp_addr_t wr_cmd_ff, nxt_wr_cmd, wr_base_ff, nxt_wr_base;
   logic [BEAT_W-1:0] wr_beat_ff, nxt_wr_beat;
   logic rd_pend_ff, nxt_rd_pend, rd_arm_ff, nxt_rd_arm, rd_act_ff, nxt_rd_act;
   qbp_addr_t rd_cmd_ff, nxt_rd_cmd, rd_base_ff, nxt_rd_base;
   logic [BEAT_W-1:0] rd_beat_ff, nxt_rd_beat;
   qbp_word_t q_ff;
   logic q_oe_n_ff;
   qbp_word_t mem [0:DEPTH-1];

   // Byte lanes whose active-low mask is high keep the stored value
   function automatic qbp_word_t merge_lanes(input qbp_word_t old_w, input qbp_word_t new_w,
      input qbp_mask_t mask_n);
      qbp_word_t res;
      res = old_w;
      for (int i = 0; i < LANES; i++) begin
         if (!mask_n[i]) begin
            res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
         end
      end
      return res;
   endfunction

   // Edge strobes; all state but the lock model moves only on link edges, so stopped clocks hold state
   wire k_rise = link.k_en;
   wire kn_rise = link.kn_en;
   wire out_odd = link.c_held ? link.k_en : link.c_en;
   wire out_even = link.c_held ? link.kn_en : link.cn_en;

   // PLL lock model: bypass skips the wait, re-enabling restarts it
   wire bypass_on = !link.pll_bypass_n;
   wire relock = link.pll_bypass_n && bypass_q_ff;
   always_comb begin
      nxt_st = st_ff;
      nxt_lock_cnt = lock_cnt_ff;
      case (st_ff)
         DS_LOCK: begin
            if (bypass_on) begin
               nxt_st = DS_READY;
            end else if (k_rise) begin
               nxt_lock_cnt = lock_cnt_ff + 1'b1;
               if (lock_cnt_ff == LOCK_LAST) begin
                  nxt_st = DS_READY;
               end
            end
         end
         DS_READY: begin
            if (relock) begin
               nxt_st = DS_LOCK;
               nxt_lock_cnt = '0;
            end
         end
         default: begin
            nxt_st = DS_LOCK;
         end
      endcase
   end

   // Command decode on the true input clock only
   wire cmd_ok = (st_ff == DS_READY) && k_rise;
   wire rd_go = cmd_ok && !link.rd_sel_n && !rd_prev_ff;
   wire wr_go = cmd_ok && !link.wr_sel_n && !wr_prev_ff && (link.rd_sel_n || rd_prev_ff);

   // Write engine: first word on K after the command, then K#, K, K#
   wire wr_start = k_rise && wr_pend_ff;
   wire wr_step = wr_act_ff && (k_rise || kn_rise);
   wire [ADDR_W+BEAT_W-1:0] wr_idx = wr_start ? {wr_cmd_ff, BEAT_FIRST} : {wr_base_ff, wr_beat_ff};
   assign nxt_wr_pend = k_rise ? wr_go : wr_pend_ff;
   assign nxt_wr_cmd = wr_go ? link.addr : wr_cmd_ff;
   assign nxt_wr_base = wr_start ? wr_cmd_ff : wr_base_ff;
   assign nxt_wr_act = wr_start || (wr_act_ff && !(wr_step && wr_beat_ff == BEAT_LAST));
   assign nxt_wr_beat = wr_start ? BEAT_SECOND : (wr_step ? wr_beat_ff + 1'b1 : wr_beat_ff);

   // Read engine: armed one K later, words on C#, C, C#, C
   wire rd_start = out_even && rd_arm_ff;
   wire rd_step = rd_act_ff && (rd_beat_ff[0] ? out_odd : out_even);
   wire [ADDR_W+BEAT_W-1:0] rd_idx = rd_start ? {rd_cmd_ff, BEAT_FIRST} : {rd_base_ff, rd_beat_ff};
   assign nxt_rd_pend = k_rise ? rd_go : rd_pend_ff;
   assign nxt_rd_arm = k_rise ? rd_pend_ff : (rd_start ? 1'b0 : rd_arm_ff);
   assign nxt_rd_cmd = rd_go ? link.addr : rd_cmd_ff;
   assign nxt_rd_base = rd_start ? rd_cmd_ff : rd_base_ff;
   assign nxt_rd_act = rd_start || (rd_act_ff && !(rd_step && rd_beat_ff == BEAT_LAST));
   assign nxt_rd_beat = rd_start ? BEAT_SECOND : (rd_step ? rd_beat_ff + 1'b1 : rd_beat_ff);
   wire rd_drive = rd_start || rd_step;

   // Lock and bypass history
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= DS_LOCK;
         lock_cnt_ff <= '0;
         bypass_q_ff <= 1'b0;
         ready_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         lock_cnt_ff <= nxt_lock_cnt;
         bypass_q_ff <= bypass_on;
         ready_ff <= (nxt_st == DS_READY);
      end
   end

   // Previous-edge command memory, updated only on K
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_prev_ff <= 1'b0;
         wr_prev_ff <= 1'b0;
      end else if (k_rise) begin
         rd_prev_ff <= rd_go;
         wr_prev_ff <= wr_go;
      end
   end

   // Write burst state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend_ff <= 1'b0;
         wr_act_ff <= 1'b0;
         wr_cmd_ff <= '0;
         wr_base_ff <= '0;
         wr_beat_ff <= BEAT_FIRST;
      end else begin
         wr_pend_ff <= nxt_wr_pend;
         wr_act_ff <= nxt_wr_act;
         wr_cmd_ff <= nxt_wr_cmd;
         wr_base_ff <= nxt_wr_base;
         wr_beat_ff <= nxt_wr_beat;
      end
   end

   // Read burst state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_pend_ff <= 1'b0;
         rd_arm_ff <= 1'b0;
         rd_act_ff <= 1'b0;
         rd_cmd_ff <= '0;
         rd_base_ff <= '0;
         rd_beat_ff <= BEAT_FIRST;
      end else begin
         rd_pend_ff <= nxt_rd_pend;
         rd_arm_ff <= nxt_rd_arm;
         rd_act_ff <= nxt_rd_act;
         rd_cmd_ff <= nxt_rd_cmd;
         rd_base_ff <= nxt_rd_base;
         rd_beat_ff <= nxt_rd_beat;
      end
   end

   // Storage: masked read-modify-write keeps the untouched lane intact
   always_ff @(posedge clk) begin
      if (wr_start || wr_step) begin
         mem[wr_idx] <= merge_lanes(mem[wr_idx], link.d, link.byte_write_mask_n);
      end
   end

   // Output register; released on the first output edge with no word
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q_ff <= '0;
         q_oe_n_ff <= 1'b1;
      end else if (out_odd || out_even) begin
         q_oe_n_ff <= !rd_drive;
         if (rd_drive) begin
            q_ff <= mem[rd_idx];
         end
      end
   end

   assign link.q = q_ff;
   assign link.q_oe_n = q_oe_n_ff;
   assign pll_ready = ready_ff;
endmodule

//--- tb/qbp_checker.sv
// Concurrent checks on the link between the SRAM port and its controller
`timescale 1ns/1ps
module qbp_checker (
   // System
   input wire logic clk,
   input wire logic reset_n,
   // Link clocks
   input wire logic k_en,
   input wire logic kn_en,
   input wire logic c_en,
   input wire logic cn_en,
   input wire logic c_held,
   // Commands and data
   input wire logic rd_sel_n,
   input wire logic wr_sel_n,
   input wire qbp_pkg::qbp_mask_t byte_write_mask_n,
   input wire qbp_pkg::qbp_word_t q,
   input wire logic q_oe_n
);
   import qbp_pkg::*;
   logic [3:0] edges_ff;
   logic last_rd_n_ff;
   logic last_wr_n_ff;
   logic read_prev_ff;
   logic [7:0] sched_ff;
   // Output edge decode; a read on the K right after a read is ignored
   wire out_edge = c_held ? (k_en | kn_en) : (c_en | cn_en);
   wire rd_take = k_en & ~rd_sel_n & ~read_prev_ff;
   // Output edges since the last accepted read; saturates so idle time cannot wrap
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         edges_ff <= 4'hf;
         last_rd_n_ff <= 1'b1;
         last_wr_n_ff <= 1'b1;
         read_prev_ff <= 1'b0;
         sched_ff <= 8'h00;
      end else begin
         if (rd_take) begin
            edges_ff <= 4'h0;
         end else if (out_edge && edges_ff != 4'hf) begin
            edges_ff <= edges_ff + 4'h1;
         end
         // Enable schedule per output edge; reads two K apart overlap, so one counter cannot track both
         if (rd_take) begin
            sched_ff <= {1'b0, sched_ff[7:1]} | 8'h78;
         end else if (out_edge) begin
            sched_ff <= {1'b0, sched_ff[7:1]};
         end
         if (k_en) begin
            last_rd_n_ff <= rd_sel_n;
            last_wr_n_ff <= wr_sel_n;
            read_prev_ff <= rd_take;
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   oe_window_a: assert property (q_oe_n == !sched_ff[0])
      else $error("read outputs enabled outside a burst");
   first_word_a: assert property ($fell(q_oe_n) |-> edges_ff == 4'h3)
      else $error("first read word at wrong output edge");
   burst_end_a: assert property ($rose(q_oe_n) |-> edges_ff == 4'h7)
      else $error("read burst not four words long");
   q_at_edge_a: assert property (!$stable(q) |-> $past(out_edge))
      else $error("read data changed off an output edge");
   rd_spacing_a: assert property (k_en && !rd_sel_n |-> last_rd_n_ff)
      else $error("reads on consecutive K edges");
   wr_spacing_a: assert property (k_en && !wr_sel_n |-> last_wr_n_ff)
      else $error("writes on consecutive K edges");
   held_quiet_a: assert property (c_held |-> !c_en && !cn_en)
      else $error("output clocks pulse while held");
   follow_k_a: assert property (!c_held |-> c_en == k_en && cn_en == kn_en)
      else $error("output clocks not matched to input clocks");
   mask_skip_a: assert property (k_en && !wr_sel_n |-> ##1 byte_write_mask_n == MASK_NONE ##5
      byte_write_mask_n == MASK_NONE)
      else $error("byte masks active outside write beats");
   clk_pair_a: assert property (k_en |-> !kn_en ##1 !k_en)
      else $error("input clock pair not alternating");
endmodule

//--- tb/quad_rate_sram_burst4_port_bench.sv
// Bench: controller and SRAM port joined by the link, driven through user requests
`timescale 1ns/1ps
module quad_rate_sram_burst4_port_bench;
   import qbp_pkg::*;
   logic clk = 0;
   logic reset_n = 0;
   logic dbg_no_pll = 0;
   logic use_k_out = 0;
   logic clk_stop = 0;
   logic req_valid = 0;
   logic req_write = 0;
   qbp_addr_t req_addr = '0;
   logic [BEATS*DATA_W-1:0] req_wdata = '0;
   logic [BEATS*LANES-1:0] req_mask_n = '1;
   logic rd_ready;
   logic wr_ready;
   logic rd_valid;
   logic link_up;
   logic pll_ready;
   qbp_word_t rd_data;
   int failures = 0;
   int compares = 0;
   int i;
   qbp_word_t mem [int];
   qbp_word_t expq [$];
   qbp_link_if link ();
   qbp_host qbp_host_inst (.clk(clk), .reset_n(reset_n), .link(link), .dbg_no_pll(dbg_no_pll),
      .use_k_out(use_k_out), .clk_stop(clk_stop), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_mask_n(req_mask_n), .rd_ready(rd_ready),
      .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .link_up(link_up));
   qbp_device qbp_device_inst (.clk(clk), .reset_n(reset_n), .link(link), .pll_ready(pll_ready));
   qbp_checker qbp_checker_inst (.clk(clk), .reset_n(reset_n), .k_en(link.k_en), .kn_en(link.kn_en),
      .c_en(link.c_en), .cn_en(link.cn_en), .c_held(link.c_held), .rd_sel_n(link.rd_sel_n),
      .wr_sel_n(link.wr_sel_n), .byte_write_mask_n(link.byte_write_mask_n), .q(link.q), .q_oe_n(link.q_oe_n));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Request stays valid after the take, so back-to-back calls re-assign it in one step
   task automatic issue(input logic wr, input qbp_addr_t a, input logic [71:0] w, input logic [7:0] m);
      int n;
      req_valid = 1;
      req_write = wr;
      req_addr = a;
      req_wdata = w;
      req_mask_n = m;
      for (n = 0; n < 900 && (wr ? wr_ready : rd_ready) !== 1'b1; n++) @(posedge clk) #1;
      if (n == 900) begin
         failures++;
         complete_run;
      end
      @(posedge clk) #1;
      // Model: a high mask bit keeps the old lane
      for (n = 0; n < BEATS; n++) begin
         if (wr) begin
            for (int l = 0; l < LANES; l++)
               if (!m[n*LANES+l]) mem[{a, n[1:0]}][l*LANE_W +: LANE_W] = w[n*DATA_W+l*LANE_W +: LANE_W];
         end else expq.push_back(mem[{a, n[1:0]}]);
      end
   endtask
   task automatic settle(input string name);
      int n;
      req_valid = 0;
      for (n = 0; n < 40 && expq.size() > 0; n++) @(posedge clk) #1;
      repeat (6) @(posedge clk) #1;
      check(expq.size(), 0);
      $display("test %s done", name);
   endtask
   // Read words are sampled at the falling edge, clear of the flop updates
   always @(negedge clk) begin
      if (rd_valid === 1'b1) check(rd_data, expq.size() > 0 ? expq.pop_front() : 'x);
   end
   initial begin
      repeat (3) @(posedge clk);
      #1 reset_n = 1;
      for (i = 0; i < 700 && link_up !== 1'b1; i++) @(posedge clk) #1;
      check(i >= 500, 1);
      check(link_up, 1);
      check(pll_ready, 1);
      settle("lock");
      issue(1, 18'h0_0010, 72'h12_3456_789a_bcde_f012, 8'h00);
      issue(1, 18'h3_ffff, 72'hfe_dcba_9876_5432_10ab, 8'h00);
      req_valid = 0;
      repeat (8) @(posedge clk) #1;
      issue(0, 18'h0_0010, '0, 8'hff);
      issue(0, 18'h3_ffff, '0, 8'hff);
      settle("burst");
      issue(1, 18'h0_0010, 72'h55_aa55_aa55_aa55_aa55, 8'h1b);
      req_valid = 0;
      repeat (8) @(posedge clk) #1;
      issue(0, 18'h0_0010, '0, 8'hff);
      settle("mask");
      issue(0, 18'h3_ffff, '0, 8'hff);
      issue(1, 18'h0_0020, 72'h0f_0f0f_0f0f_0f0f_0f0f, 8'h00);
      issue(0, 18'h0_0010, '0, 8'hff);
      settle("mixed");
      use_k_out = 1;
      issue(0, 18'h0_0020, '0, 8'hff);
      settle("held output clocks");
      use_k_out = 0;
      clk_stop = 1;
      repeat (20) @(posedge clk) #1;
      clk_stop = 0;
      issue(0, 18'h0_0010, '0, 8'hff);
      settle("clock stop");
      reset_n = 0;
      dbg_no_pll = 1;
      repeat (3) @(posedge clk) #1;
      reset_n = 1;
      check(link.q_oe_n, 1);
      for (i = 0; i < 700 && link_up !== 1'b1; i++) @(posedge clk) #1;
      check(i < 8, 1);
      issue(0, 18'h3_ffff, '0, 8'hff);
      settle("bypass");
      complete_run;
   end
endmodule
